/* common/dlog_pkg.sv */
// Purpose: constants and carrier types for the drive log sector builder
// Assumes: 10 MHz device clock, 512-byte log sectors
// Notes: byte k of every packed byte array is log byte offset k
package dlog_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
	localparam int MS_PER_HOUR = 3600000;
	localparam int SECTOR_BYTES = 512;
	localparam int ERR_SLOTS = 4;
	localparam int ERR_SLOT_BYTES = 124;
	localparam int CMD_SNAPS = 5;
	localparam int CMD_SNAP_BYTES = 18;
	localparam int ERR_SNAP_BYTES = 34;
	localparam int ST_SLOTS = 18;
	localparam int ST_DESC_BYTES = 26;
	// log addresses
	localparam logic [7:0] LOG_DIR = 8'h00;
	localparam logic [7:0] LOG_ERR = 8'h03;
	localparam logic [7:0] LOG_ST = 8'h07;
	localparam logic [7:0] LOG_HOST_LO = 8'h80;
	localparam logic [7:0] LOG_HOST_HI = 8'h9f;
	localparam logic [15:0] DIR_VERSION = 16'h0001;
	localparam logic [15:0] DIR_HOST_SECTORS = 16'h0010;
	localparam logic [15:0] DIR_ONE_SECTOR = 16'h0001;
	localparam logic [7:0] LOG_VERSION = 8'h01;
	// sector offsets
	localparam logic [8:0] OFF_INDEX_LO = 9'h002;
	localparam logic [8:0] OFF_INDEX_HI = 9'h003;
	localparam logic [8:0] OFF_ERR_SLOT0 = 9'h004;
	localparam logic [8:0] OFF_ERR_COUNT = 9'h1f4;
	localparam logic [8:0] OFF_ST_SLOT0 = 9'h004;
	localparam logic [8:0] OFF_ST_END = 9'h1f2;
	localparam logic [8:0] OFF_CHECKSUM = 9'h1ff;
	localparam logic [2:0] ERR_IDX_MAX = 3'h4;
	localparam logic [4:0] ST_IDX_MAX = 5'h12;

	// command-block register selector
	typedef enum logic [2:0] {
		DLOG_REG_DEVCTL = 3'b000,
		DLOG_REG_FEATURE = 3'b001,
		DLOG_REG_COUNT = 3'b010,
		DLOG_REG_SECTOR = 3'b011,
		DLOG_REG_CYL_LO = 3'b100,
		DLOG_REG_CYL_HI = 3'b101,
		DLOG_REG_DEVHEAD = 3'b110,
		DLOG_REG_COMMAND = 3'b111
	} dlog_reg_t;

	// low nibble of the error snapshot state byte
	typedef enum logic [3:0] {
		DLOG_ST_UNKNOWN = 4'h0,
		DLOG_ST_SLEEP = 4'h1,
		DLOG_ST_STANDBY = 4'h2,
		DLOG_ST_ACTIVE = 4'h3,
		DLOG_ST_SCAN = 4'h4
	} dlog_cond_t;

	typedef struct packed {
		logic [18:0][7:0] vendor;
		logic [1:0][7:0] cyl_hi; // [0] seen with hob clear, [1] set
		logic [1:0][7:0] cyl_lo;
		logic [1:0][7:0] sector;
		logic [1:0][7:0] count;
		logic [7:0] devhead;
		logic [7:0] status;
		logic [7:0] error;
		logic [3:0] state_vendor;
		dlog_cond_t state;
	} dlog_err_snap_t;

	typedef logic [ST_DESC_BYTES-1:0][7:0] dlog_st_desc_t;

	typedef struct packed {
		logic [7:0] log;
		logic [15:0] sector;
		logic [15:0] count;
	} dlog_rd_req_t;

	typedef enum logic [0:0] {
		DLOG_RD_IDLE = 1'b0,
		DLOG_RD_SEND = 1'b1
	} dlog_rd_fsm_t;
endpackage : dlog_pkg

/* rtl/dlog_builder.sv */
// Summary of operation
// - directory starts with version word 0001h
// - directory sector count per log, low first
// - logs 80h-9Fh listed as sixteen sectors
// - rejected commands never create error entries
// - error log byte 0 is 01h, then reserved
// - four 124-byte slots, count, checksum
// - error index names newest slot, 0..4
// - last four errors kept circularly
// - unused error slots read as zero
// - five command snapshots then error snapshot
// - command snapshot layout with millisecond stamp
// - low byte latest write, high byte previous
// - error snapshot layout with hours stamp
// - error snapshot pairs split by hob bit
// - state byte low nibble encodes device condition
// - lifetime error count saturates, skips rejects
// - self-test log takes 28 and 48-bit entries
// - eighteen 26-byte descriptors, vendor, reserved, checksum
// - descriptors circular, unused ones zero
// - self-test log byte 0 is 01h
// - self-test index names newest, 0..18
// - checksum makes all 512 bytes sum zero
// - invalid or disabled log read is aborted
//
// Purpose: builds directory, error and self-test log sectors
// Assumes: all inputs come from logic on i_clock
// Notes: one byte per accepted beat, sector streamed from byte 0
`timescale 1ns/1ns
`default_nettype none
module dlog_builder
	import dlog_pkg::*;
#(
	parameter int P_CYC_PER_MS = CYC_PER_MS,
	parameter int P_MS_PER_HOUR = MS_PER_HOUR
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// command-block register writes
	input wire logic i_reg_wr,
	input wire dlog_reg_t i_reg_sel,
	input wire logic [7:0] i_reg_data,
	// error report
	input wire logic i_err_evt,
	input wire logic i_err_rejected,
	input wire dlog_err_snap_t i_err_snap,
	// self-test completion
	input wire logic i_st_evt,
	input wire dlog_st_desc_t i_st_desc,
	// log read request and feature enable
	input wire logic i_rd_req,
	input wire dlog_rd_req_t i_rd,
	input wire logic i_smart_en,
	// sector byte stream
	input wire logic i_rd_ready,
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	output logic o_rd_last,
	output logic o_rd_abort
);
	if (P_CYC_PER_MS < 2 || P_MS_PER_HOUR < 2) begin : g_chk
		$error("dlog_builder: time counts must be at least two");
	end
	if (int'(ERR_IDX_MAX) != ERR_SLOTS) begin : g_eidx
		$error("dlog_builder: error index limit must match slot count");
	end
	if (int'(ST_IDX_MAX) != ST_SLOTS) begin : g_sidx
		$error("dlog_builder: self-test index limit must match slots");
	end

	typedef struct packed {
		logic rst_meta;
		logic rst_ok;
		logic [7:0][1:0][7:0] shadow; // [reg][0 latest, 1 previous]
		logic [CMD_SNAPS-1:0][CMD_SNAP_BYTES-1:0][7:0] hist;
		logic [ERR_SLOTS-1:0][ERR_SLOT_BYTES-1:0][7:0] eslot;
		logic [2:0] err_idx;
		logic [15:0] err_cnt;
		logic [ST_SLOTS-1:0][ST_DESC_BYTES-1:0][7:0] st;
		logic [4:0] st_idx;
		logic [31:0] cyc;
		logic [31:0] ms;
		logic [31:0] ms_in_hour;
		logic [15:0] hours;
		dlog_rd_fsm_t fsm;
		logic [7:0] log;
		logic [9:0] off;
		logic [7:0] sum;
		logic valid;
		logic [7:0] data;
		logic last;
		logic abort;
	} dlog_state_t;

	dlog_state_t s;
	dlog_state_t next_s;

	function automatic logic [7:0] dir_byte(input logic [8:0] off);
		logic [7:0] addr;
		logic [15:0] cnt;
		addr = off[8:1];
		cnt = 16'h0000;
		if (addr == LOG_DIR) begin
			cnt = DIR_VERSION;
		end else if (addr == LOG_ERR || addr == LOG_ST) begin
			cnt = DIR_ONE_SECTOR;
		end else if (addr >= LOG_HOST_LO && addr <= LOG_HOST_HI) begin
			cnt = DIR_HOST_SECTORS;
		end
		dir_byte = off[0] ? cnt[15:8] : cnt[7:0];
	endfunction : dir_byte

	function automatic logic [7:0] err_byte(input dlog_state_t st,
			input logic [8:0] off);
		logic [8:0] base;
		err_byte = 8'h00;
		base = OFF_ERR_SLOT0;
		if (off == 9'h000) begin
			err_byte = LOG_VERSION;
		end else if (off == OFF_INDEX_LO) begin
			err_byte = {5'h00, st.err_idx};
		end else if (off == OFF_ERR_COUNT) begin
			err_byte = st.err_cnt[7:0];
		end else if (off == OFF_ERR_COUNT + 9'h001) begin
			err_byte = st.err_cnt[15:8];
		end
		for (int k = 0; k < ERR_SLOTS; k++) begin
			if (off >= base && off < base + 9'(ERR_SLOT_BYTES)) begin
				err_byte = st.eslot[k][7'(off - base)];
			end
			base = base + 9'(ERR_SLOT_BYTES);
		end
	endfunction : err_byte

	function automatic logic [7:0] st_byte(input dlog_state_t st,
			input logic [8:0] off);
		logic [8:0] base;
		st_byte = 8'h00;
		base = OFF_ST_SLOT0;
		if (off == 9'h000) begin
			st_byte = LOG_VERSION;
		end else if (off == OFF_INDEX_LO) begin
			st_byte = {3'h0, st.st_idx};
		end
		// vendor and reserved bytes past the descriptors read zero
		for (int k = 0; k < ST_SLOTS; k++) begin
			if (off >= base && off < base + 9'(ST_DESC_BYTES)) begin
				st_byte = st.st[k][5'(off - base)];
			end
			base = base + 9'(ST_DESC_BYTES);
		end
	endfunction : st_byte

	function automatic logic [7:0] sector_byte(input dlog_state_t st,
			input logic [8:0] off);
		if (off == OFF_CHECKSUM) begin
			sector_byte = 8'(-st.sum);
		end else if (st.log == LOG_ERR) begin
			sector_byte = err_byte(st, off);
		end else if (st.log == LOG_ST) begin
			sector_byte = st_byte(st, off);
		end else begin
			sector_byte = dir_byte(off);
		end
	endfunction : sector_byte

	always_comb begin
		logic [CMD_SNAP_BYTES-1:0][7:0] csnap;
		logic [ERR_SNAP_BYTES-1:0][7:0] esnap;
		logic [2:0] eidx;
		logic [4:0] sidx;
		logic rd_ok;
		logic [7:0] b;
		next_s = s;
		csnap = '0;
		esnap = '0;
		eidx = 3'h0;
		sidx = 5'h0;
		rd_ok = 1'b0;
		b = 8'h00;
		next_s.rst_meta = 1'b1;
		next_s.rst_ok = s.rst_meta;
		next_s.abort = 1'b0;

		// time stamps
		// ms stamp wraps after about 49 days, hours after 7 years
		if (s.cyc >= 32'(P_CYC_PER_MS - 1)) begin
			next_s.cyc = 32'h0;
			next_s.ms = s.ms + 32'h1;
			if (s.ms_in_hour >= 32'(P_MS_PER_HOUR - 1)) begin
				next_s.ms_in_hour = 32'h0;
				next_s.hours = s.hours + 16'h1;
			end else begin
				next_s.ms_in_hour = s.ms_in_hour + 32'h1;
			end
		end else begin
			next_s.cyc = s.cyc + 32'h1;
		end

		// command snapshot taken when the command register is written
		// an error in this cycle still logs the history before the write
		csnap[0] = s.shadow[DLOG_REG_DEVCTL][0];
		for (int r = 1; r < 6; r++) begin
			csnap[2 * r - 1] = s.shadow[r][0];
			csnap[2 * r] = s.shadow[r][1];
		end
		csnap[11] = s.shadow[DLOG_REG_DEVHEAD][0];
		csnap[12] = i_reg_data;
		csnap[17:14] = s.ms;
		if (i_reg_wr) begin
			next_s.shadow[i_reg_sel][1] = s.shadow[i_reg_sel][0];
			next_s.shadow[i_reg_sel][0] = i_reg_data;
			if (i_reg_sel == DLOG_REG_COMMAND) begin
				next_s.hist = {csnap, s.hist[CMD_SNAPS-1:1]};
			end
		end

		// error snapshot
		esnap[1] = i_err_snap.error;
		esnap[3:2] = i_err_snap.count;
		esnap[5:4] = i_err_snap.sector;
		esnap[7:6] = i_err_snap.cyl_lo;
		esnap[9:8] = i_err_snap.cyl_hi;
		esnap[10] = i_err_snap.devhead;
		esnap[11] = i_err_snap.status;
		esnap[30:12] = i_err_snap.vendor;
		esnap[31] = {i_err_snap.state_vendor, i_err_snap.state};
		esnap[33:32] = s.hours;
		if (i_err_evt && !i_err_rejected) begin
			eidx = (s.err_idx == 3'h0 || s.err_idx == ERR_IDX_MAX) ?
				3'h1 : s.err_idx + 3'h1;
			next_s.err_idx = eidx;
			next_s.eslot[eidx - 3'h1] = {esnap, s.hist};
			if (s.err_cnt != 16'hffff) begin
				next_s.err_cnt = s.err_cnt + 16'h1;
			end
		end

		// self-test descriptors, 28-bit ones carry zero upper lba bytes
		if (i_st_evt) begin
			sidx = (s.st_idx == 5'h0 || s.st_idx == ST_IDX_MAX) ?
				5'h01 : s.st_idx + 5'h01;
			next_s.st_idx = sidx;
			next_s.st[sidx - 5'h01] = i_st_desc;
		end

		// log read
		// only single-sector reads from sector zero are served
		unique case (s.fsm)
			DLOG_RD_IDLE: begin
				rd_ok = i_rd.count == 16'h0001 && i_rd.sector == 16'h0000 &&
					(i_rd.log == LOG_DIR || (i_smart_en &&
					(i_rd.log == LOG_ERR || i_rd.log == LOG_ST)));
				if (i_rd_req && !rd_ok) begin
					next_s.abort = 1'b1;
				end else if (i_rd_req) begin
					next_s.fsm = DLOG_RD_SEND;
					next_s.log = i_rd.log;
					next_s.off = 10'h000;
					next_s.sum = 8'h00;
				end
			end
			DLOG_RD_SEND: begin
				// idle beat after each byte keeps the adder off the ready path
				if (s.valid && i_rd_ready) begin
					next_s.valid = 1'b0;
					next_s.last = 1'b0;
					if (s.last) begin
						next_s.fsm = DLOG_RD_IDLE;
					end
				end else if (!s.valid) begin
					b = sector_byte(s, s.off[8:0]);
					next_s.data = b;
					next_s.valid = 1'b1;
					next_s.last = s.off[8:0] == OFF_CHECKSUM;
					next_s.sum = s.sum + b;
					next_s.off = s.off + 10'h001;
				end
			end
		endcase
	end

	// slots start zeroed so unused entries read as zero
	// other state holds until the reset copy has passed both stages
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			s <= '0;
		end else if (!s.rst_ok) begin
			s.rst_meta <= next_s.rst_meta;
			s.rst_ok <= next_s.rst_ok;
		end else begin
			s <= next_s;
		end
	end

	assign o_rd_valid = s.valid;
	assign o_rd_data = s.data;
	assign o_rd_last = s.last;
	assign o_rd_abort = s.abort;
endmodule : dlog_builder
`default_nettype wire

/* dv/dlog_builder_props.sv */
// Purpose: port assertions for the log sector builder
// Assumes: requests arrive while idle or during a transfer
// Notes: bound to every dlog_builder
`timescale 1ns/1ns
`default_nettype none
module dlog_builder_props
	import dlog_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// read side
	input wire logic i_rd_req,
	input wire dlog_rd_req_t i_rd,
	input wire logic i_smart_en,
	input wire logic i_rd_ready,
	input wire logic o_rd_valid,
	input wire logic [7:0] o_rd_data,
	input wire logic o_rd_last,
	input wire logic o_rd_abort
);
	typedef struct packed {
		logic busy;
		logic pend;
		logic [9:0] nacc;
	} dlog_chk_t;
	dlog_chk_t st;
	dlog_chk_t next_st;
	wire logic take = o_rd_valid && i_rd_ready;
	wire logic idle = !st.busy && !st.pend && !o_rd_valid;
	always_comb begin
		next_st.pend = i_rd_req && idle;
		next_st.busy = (o_rd_valid || st.busy) && !(take && o_rd_last);
		next_st.nacc = (take && o_rd_last) ? 10'h000 : st.nacc + 10'(take);
	end
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			st <= '0;
		else
			st <= next_st;
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	sequence s_dir_req;
		i_rd_req && idle && i_rd == dlog_rd_req_t'{LOG_DIR, 16'h0000, 16'h0001};
	endsequence
	sequence s_first_byte;
		##2 o_rd_valid && o_rd_data == 8'h01;
	endsequence
	a_dir_version: assert property (s_dir_req |-> s_first_byte)
		else $error("directory byte 0 wrong");
	a_bad_read: assert property (i_rd_req && idle && (i_rd.log == 8'h06
		|| i_rd.count != 16'h0001 || i_rd.sector != 16'h0000) |=> o_rd_abort)
		else $error("bad read not aborted");
	a_smart_off: assert property (i_rd_req && idle && i_rd.log == LOG_ERR
		&& !i_smart_en |=> o_rd_abort)
		else $error("disabled log not aborted");
	a_abort_cause: assert property (o_rd_abort |-> $past(i_rd_req) && !o_rd_valid)
		else $error("abort without request");
	a_busy_ignore: assert property (i_rd_req && st.busy |=> !o_rd_abort)
		else $error("abort during transfer");
	a_hold_byte: assert property (o_rd_valid && !i_rd_ready |=> o_rd_valid
		&& $stable(o_rd_data) && $stable(o_rd_last))
		else $error("byte dropped while stalled");
	a_next_byte: assert property (take && !o_rd_last |=> !o_rd_valid ##1 o_rd_valid)
		else $error("byte pacing wrong");
	a_last_count: assert property (o_rd_last |-> o_rd_valid && st.nacc == 10'h1ff)
		else $error("last not on byte 511");
	a_end_idle: assert property (take && o_rd_last |=> !o_rd_valid[*2])
		else $error("bytes after last");
endmodule : dlog_builder_props
bind dlog_builder dlog_builder_props u_props (.i_clock(i_clock), .i_rstn(i_rstn),
	.i_rd_req(i_rd_req), .i_rd(i_rd), .i_smart_en(i_smart_en),
	.i_rd_ready(i_rd_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
	.o_rd_last(o_rd_last), .o_rd_abort(o_rd_abort));
`default_nettype wire

/* dv/dlog_host.sv */
// Purpose: host side that takes sector bytes
// Assumes: whole sectors only
// Notes: slow mode accepts one cycle in three
`timescale 1ns/1ns
`default_nettype none
module dlog_host (
	// clock and mode
	input wire logic i_clock,
	input wire logic i_slow,
	// byte stream
	input wire logic i_rd_valid,
	input wire logic [7:0] i_rd_data,
	output logic o_rd_ready
);
	logic [7:0] mem [512];
	int n = 0;
	logic [1:0] t = 2'h0;
	always @(posedge i_clock) begin
		t <= (t == 2'h2) ? 2'h0 : t + 2'h1;
		o_rd_ready <= !i_slow || t == 2'h0;
		if (i_rd_valid && o_rd_ready) begin
			mem[n % 512] <= i_rd_data;
			n <= n + 1;
		end
	end
endmodule : dlog_host
`default_nettype wire

/* dv/tb.sv */
// Purpose: self-checking bench for the log sector builder
// Assumes: command writes land before the first millisecond
// Notes: sectors are rebuilt from a behavioural model
`timescale 1ns/1ns
`default_nettype none
module tb;
	import dlog_pkg::*;
	logic i_clock = 1'b0;
	logic i_rstn = 1'b0;
	logic i_reg_wr = 1'b0;
	dlog_reg_t i_reg_sel = DLOG_REG_DEVCTL;
	logic [7:0] i_reg_data = 8'h00;
	logic i_err_evt = 1'b0;
	logic i_err_rejected = 1'b0;
	dlog_err_snap_t i_err_snap = '0;
	logic i_st_evt = 1'b0;
	dlog_st_desc_t i_st_desc = '0;
	logic i_rd_req = 1'b0;
	dlog_rd_req_t i_rd = '0;
	logic i_smart_en = 1'b0;
	logic i_slow = 1'b0;
	logic i_rd_ready, o_rd_valid, o_rd_last, o_rd_abort;
	logic [7:0] o_rd_data;
	logic [7:0] seed = 8'h35;
	logic [7:0] mdl [512];
	logic [7:0] wv [3];
	logic [247:0] r;
	dlog_st_desc_t d;
	dlog_err_snap_t es [4];
	dlog_st_desc_t sd [18];
	logic [39:0] bad [5] = '{40'h06_0000_0001, 40'h80_0000_0001,
		40'h00_0000_0002, 40'h00_0001_0001, 40'h10_0000_0001};
	int eidx = 0, ecnt = 0, sidx = 0, error_cnt = 0, num_checks = 0;
	always #50 i_clock = ~i_clock;
	dlog_builder uut (.i_clock(i_clock), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr),
		.i_reg_sel(i_reg_sel), .i_reg_data(i_reg_data), .i_err_evt(i_err_evt),
		.i_err_rejected(i_err_rejected), .i_err_snap(i_err_snap),
		.i_st_evt(i_st_evt), .i_st_desc(i_st_desc), .i_rd_req(i_rd_req),
		.i_rd(i_rd), .i_smart_en(i_smart_en), .i_rd_ready(i_rd_ready),
		.o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_rd_last(o_rd_last),
		.o_rd_abort(o_rd_abort));
	dlog_host host (.i_clock(i_clock), .i_slow(i_slow), .i_rd_valid(o_rd_valid),
		.i_rd_data(o_rd_data), .o_rd_ready(i_rd_ready));
	function automatic logic [7:0] rnd();
		seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
		return seed;
	endfunction : rnd
	task automatic chk(input string nm, input logic [15:0] got,
		input logic [15:0] want);
		num_checks++;
		if (got !== want) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, want, got);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic build(input logic [7:0] lg);
		int s;
		foreach (mdl[k]) mdl[k] = 8'h00;
		mdl[0] = 8'h01;
		if (lg == LOG_DIR) begin
			mdl[6] = 8'h01;
			mdl[14] = 8'h01;
			for (int k = 256; k < 320; k += 2) mdl[k] = 8'h10;
		end else if (lg == LOG_ERR) begin
			mdl[2] = 8'(eidx);
			{mdl[501], mdl[500]} = 16'(ecnt);
			for (int i = 0; i < ecnt && i < 4; i++) begin
				s = 4 + 124 * i;
				mdl[s + 73] = wv[1];
				mdl[s + 74] = wv[0];
				mdl[s + 84] = wv[2];
				s += 90;
				mdl[s + 1] = es[i].error;
				{mdl[s + 3], mdl[s + 2]} = es[i].count;
				{mdl[s + 5], mdl[s + 4]} = es[i].sector;
				{mdl[s + 7], mdl[s + 6]} = es[i].cyl_lo;
				{mdl[s + 9], mdl[s + 8]} = es[i].cyl_hi;
				mdl[s + 10] = es[i].devhead;
				mdl[s + 11] = es[i].status;
				for (int k = 0; k < 19; k++) mdl[s + 12 + k] = es[i].vendor[k];
				mdl[s + 31] = {es[i].state_vendor, es[i].state};
			end
		end else begin
			mdl[2] = 8'(sidx);
			for (int i = 0; i < 18; i++)
				for (int k = 0; k < 26; k++) mdl[4 + 26 * i + k] = sd[i][k];
		end
		s = 0;
		for (int k = 0; k < 511; k++) s += mdl[k];
		mdl[511] = 8'(-s);
	endtask : build
	task automatic rd(input logic [39:0] q, input logic ok);
		int base;
		int t;
		base = host.n;
		@(posedge i_clock);
		i_rd_req <= 1'b1;
		i_rd <= q;
		@(posedge i_clock);
		i_rd_req <= 1'b0;
		@(negedge i_clock);
		chk("abort", 16'(o_rd_abort), 16'(!ok));
		if (ok) begin
			build(q[39:32]);
			repeat (9) @(posedge i_clock);
			i_rd_req <= 1'b1;
			i_rd.log <= 8'h06;
			@(posedge i_clock);
			i_rd_req <= 1'b0;
			t = 0;
			while (host.n < base + 512 && t < 5000) begin
				@(posedge i_clock);
				t++;
			end
			chk("timeout", 16'(t >= 5000), 16'h0000);
			foreach (mdl[k]) chk("byte", 16'(host.mem[k]), 16'(mdl[k]));
		end
	endtask : rd
	initial begin
		foreach (sd[i]) sd[i] = '0;
		foreach (wv[k]) wv[k] = rnd();
		repeat (5) @(posedge i_clock);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_clock);
		for (int k = 0; k < 3; k++) begin
			i_reg_wr <= 1'b1;
			i_reg_sel <= k < 2 ? DLOG_REG_FEATURE : DLOG_REG_COMMAND;
			i_reg_data <= wv[k];
			@(posedge i_clock);
		end
		i_reg_wr <= 1'b0;
		rd(40'h00_0000_0001, 1'b1);
		i_smart_en <= 1'b1;
		i_slow <= 1'b1;
		rd(40'h07_0000_0001, 1'b1);
		foreach (bad[k]) rd(bad[k], 1'b0);
		i_smart_en <= 1'b0;
		rd(40'h03_0000_0001, 1'b0);
		i_smart_en <= 1'b1;
		rd(40'h03_0000_0001, 1'b1);
		for (int k = 0; k < 6; k++) begin
			@(posedge i_clock);
			for (int j = 0; j < 31; j++) r = {r[239:0], rnd()};
			i_err_evt <= 1'b1;
			i_err_rejected <= k == 2;
			i_err_snap <= dlog_err_snap_t'(r);
			if (k != 2) begin
				eidx = eidx == 4 ? 1 : eidx + 1;
				es[eidx - 1] = dlog_err_snap_t'(r);
				ecnt++;
			end
		end
		@(posedge i_clock);
		i_err_evt <= 1'b0;
		rd(40'h03_0000_0001, 1'b1);
		for (int k = 0; k < 19; k++) begin
			@(posedge i_clock);
			for (int j = 0; j < 26; j++) d[j] = rnd();
			i_st_evt <= 1'b1;
			i_st_desc <= d;
			sidx = sidx == 18 ? 1 : sidx + 1;
			sd[sidx - 1] = d;
		end
		@(posedge i_clock);
		i_st_evt <= 1'b0;
		i_slow <= 1'b0;
		rd(40'h07_0000_0001, 1'b1);
		close_out();
	end
	initial begin
		repeat (40000) @(posedge i_clock);
		error_cnt++;
		close_out();
	end
endmodule : tb
`default_nettype wire
